//--- common/pss_pkg.sv
// Constants and types for the PID setpoint select and PI term block
package pss_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int unsigned NUM_DI = 16;
    localparam int unsigned NUM_SP = 7;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets (word addresses)
    localparam logic [15:0] A_MODE = 16'h0700;
    localparam logic [15:0] A_OFFSET = 16'h0704;
    localparam logic [15:0] A_SP_BASE = 16'h0706;
    localparam logic [15:0] A_SP_LAST = 16'h070C;
    localparam logic [15:0] A_KP = 16'h070D;
    localparam logic [15:0] A_TI = 16'h070E;
    localparam logic [15:0] A_STATUS = 16'h0720;
    localparam logic [15:0] A_FREQ = 16'h0721;
    localparam logic [15:0] A_FN_BASE = 16'h0800;
    localparam logic [15:0] A_FN_LAST = 16'h080F;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and ranges
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] KP_RST = 16'h000A;  // 1.0 in 0.1 steps
    localparam logic [15:0] KP_MAX = 16'h03E8;  // 100.0
    localparam logic [15:0] TI_RST = 16'h0064;  // 1.00 s in 0.01 s steps
    localparam logic [15:0] TI_MAX = 16'h2710;  // 100.00 s
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [7:0] FN_RST = 8'h00;
    localparam logic signed [15:0] OUT_MAX = 16'sh7FFF;
    localparam logic signed [15:0] OUT_MIN = -16'sh8000;
    localparam logic signed [31:0] ACC_MAX = 32'sh7FFFFFFF;
    localparam logic signed [31:0] ACC_MIN = -32'sh80000000;

    ////////////////////////////////////////////////////////////////////////
    // Input terminal function codes
    localparam logic [7:0] FN_NONE = 8'h00;
    localparam logic [7:0] FN_BIT1 = 8'h01;
    localparam logic [7:0] FN_BIT2 = 8'h02;
    localparam logic [7:0] FN_BIT3 = 8'h03;

    ////////////////////////////////////////////////////////////////////////
    // Timing and scaling
    localparam int unsigned CLK_NS = 50;
    localparam int unsigned UPD_US = 1000;
    localparam int unsigned UPD_CYC = UPD_US * 1000 / CLK_NS;
    localparam int unsigned TI_UNIT_US = 10000;
    localparam int unsigned UPD_PER_TI = TI_UNIT_US / UPD_US;
    localparam logic signed [33:0] KP_DIV = 34'sh0A;

    ////////////////////////////////////////////////////////////////////////
    // Status fields
    localparam int unsigned STAT_ACT_BIT = 4;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pss_bus_t;

    typedef enum {PSS_IDLE, PSS_SEL, PSS_INT, PSS_OUT} pss_state_t;

endpackage

//--- core/pss_core.sv
// PID setpoint selection and PI term computation
//
// Functional notes
// - A terminal with function code 0 has no effect at all.
// - Function codes 1, 2, 3 make a terminal setpoint-select bit 1, 2, 3.
// - Stored setpoints are selectable only while the action mode is nonzero.
// - With all select inputs off the setpoint comes from the source input.
// - Select bits are binary, bit 1 LSB; codes 1-7 pick setpoints 1-7.
// - Gain is 16-bit unsigned, 0.0 to 100.0, default 1.0, larger is stronger.
// - With integral and derivative at zero only the P term drives the output.
// - Integral time 0.00-100.00 s, 16-bit, default 1.00; shorter is stronger.
// - An integral time of 0.00 disables the integral term.
// - The enabled integrator accumulates while the error is nonzero.
// - PID is enabled only when the action mode is above zero.
// - The offset value is added to the PID output to form the command.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pss_core #(
    parameter int unsigned UPD_CYCLES = pss_pkg::UPD_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire pss_pkg::pss_bus_t bus_i,
    output logic [15:0] rd_data_q,
    // Field contacts and loop signals
    input wire logic [15:0] di_i,
    input wire logic [15:0] pv_i,
    input wire logic [15:0] dflt_sp_i,
    // Results
    output logic signed [15:0] freq_cmd_q,
    output logic [15:0] setpoint_q,
    output logic [2:0] sel_code_q,
    output logic pid_active_q
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [15:0] mode_q;
    logic signed [15:0] off_q;
    logic [15:0] kp_q;
    logic [15:0] ti_q;
    logic [15:0] sp_q [pss_pkg::NUM_SP];
    logic [7:0] fn_q [pss_pkg::NUM_DI];
    logic [15:0] di_m_q;
    logic [15:0] di_s_q;
    logic [31:0] cnt_q;
    logic tick_q;
    pss_pkg::pss_state_t st_q;
    logic signed [16:0] err_q;
    logic signed [31:0] acc_q;
    logic [2:0] code_w;
    logic [15:0] nz_w;
    logic [2:0] idx_w;
    logic pid_en_w;
    logic [15:0] sp_pick_w;
    logic signed [16:0] err_w;
    logic signed [32:0] acc_n_w;
    logic signed [31:0] acc_sat_w;
    logic signed [33:0] p_prod_w;
    logic signed [33:0] p_term_w;
    logic signed [33:0] den_w;
    logic signed [33:0] i_term_w;
    logic signed [35:0] sum_w;
    logic signed [15:0] out_w;
    logic [15:0] rd_val_w;
    logic [15:0] wr_idx_w;

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    assign wr_idx_w = bus_i.addr - pss_pkg::A_SP_BASE;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mode_q <= pss_pkg::MODE_RST;
            off_q <= '0;
            kp_q <= pss_pkg::KP_RST;
            ti_q <= pss_pkg::TI_RST;
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                pss_pkg::A_MODE: mode_q <= bus_i.wdata;
                pss_pkg::A_OFFSET: off_q <= $signed(bus_i.wdata);
                pss_pkg::A_KP: begin
                    // Clip to the documented span
                    kp_q <= (bus_i.wdata > pss_pkg::KP_MAX) ?
                        pss_pkg::KP_MAX : bus_i.wdata;
                end
                pss_pkg::A_TI: begin
                    ti_q <= (bus_i.wdata > pss_pkg::TI_MAX) ?
                        pss_pkg::TI_MAX : bus_i.wdata;
                end
                default: ;
            endcase
        end
    end

    // Stored setpoints one to seven
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int i = 0; i < pss_pkg::NUM_SP; i++) begin
                sp_q[i] <= pss_pkg::SP_RST;
            end
        end else if (bus_i.wr && bus_i.addr >= pss_pkg::A_SP_BASE &&
                     bus_i.addr <= pss_pkg::A_SP_LAST) begin
            sp_q[wr_idx_w[2:0]] <= bus_i.wdata;
        end
    end

    // Terminal function codes
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int i = 0; i < pss_pkg::NUM_DI; i++) begin
                fn_q[i] <= pss_pkg::FN_RST;
            end
        end else if (bus_i.wr && bus_i.addr >= pss_pkg::A_FN_BASE &&
                     bus_i.addr <= pss_pkg::A_FN_LAST) begin
            fn_q[bus_i.addr[3:0]] <= bus_i.wdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads
    always_comb begin
        rd_val_w = '0;
        if (bus_i.addr >= pss_pkg::A_SP_BASE &&
            bus_i.addr <= pss_pkg::A_SP_LAST) begin
            rd_val_w = sp_q[wr_idx_w[2:0]];
        end else if (bus_i.addr >= pss_pkg::A_FN_BASE &&
                     bus_i.addr <= pss_pkg::A_FN_LAST) begin
            rd_val_w = {8'h00, fn_q[bus_i.addr[3:0]]};
        end else begin
            case (bus_i.addr)
                pss_pkg::A_MODE: rd_val_w = mode_q;
                pss_pkg::A_OFFSET: rd_val_w = off_q;
                pss_pkg::A_KP: rd_val_w = kp_q;
                pss_pkg::A_TI: rd_val_w = ti_q;
                pss_pkg::A_STATUS: begin
                    rd_val_w[2:0] = sel_code_q;
                    rd_val_w[pss_pkg::STAT_ACT_BIT] = pid_active_q;
                end
                pss_pkg::A_FREQ: rd_val_w = freq_cmd_q;
                default: rd_val_w = '0;
            endcase
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= bus_i.rd ? rd_val_w : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Contact synchroniser
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            di_m_q <= '0;
            di_s_q <= '0;
        end else begin
            di_m_q <= di_i;
            di_s_q <= di_m_q;
        end
    end

    // Update tick divider
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q == 32'(UPD_CYCLES - 1)) begin
            cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Select code from terminals
    always_comb begin
        code_w = '0;
        nz_w = '0;
        for (int i = 0; i < pss_pkg::NUM_DI; i++) begin
            nz_w[i] = (fn_q[i] != pss_pkg::FN_NONE);
            if (di_s_q[i]) begin
                case (fn_q[i])
                    pss_pkg::FN_BIT1: code_w[0] = 1'b1;
                    pss_pkg::FN_BIT2: code_w[1] = 1'b1;
                    pss_pkg::FN_BIT3: code_w[2] = 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // Setpoint choice and error
    assign pid_en_w = (mode_q != pss_pkg::MODE_RST);
    assign idx_w = code_w - 3'h1;
    assign sp_pick_w = (pid_en_w && code_w != '0) ?
        sp_q[idx_w] : dflt_sp_i;
    assign err_w = $signed({1'b0, sp_pick_w}) - $signed({1'b0, pv_i});

    ////////////////////////////////////////////////////////////////////////
    // Integrator with saturation
    assign acc_n_w = 33'(acc_q) + 33'(err_q);
    assign acc_sat_w = (acc_n_w[32] == acc_n_w[31]) ? acc_n_w[31:0] :
        (acc_n_w[32] ? pss_pkg::ACC_MIN : pss_pkg::ACC_MAX);

    // P and I terms, offset and output clip
    assign p_prod_w = $signed({1'b0, kp_q}) * err_q;
    assign p_term_w = p_prod_w / pss_pkg::KP_DIV;
    assign den_w = $signed({18'h0, ti_q}) *
        $signed(34'(pss_pkg::UPD_PER_TI));
    // Signed zero keeps the division signed for a negative integral
    assign i_term_w = (ti_q == '0) ? 34'sh0 : 34'(acc_q) / den_w;
    assign sum_w = 36'(p_term_w) + 36'(i_term_w) + 36'(off_q);
    assign out_w = (sum_w[35:15] == '0 || sum_w[35:15] == '1) ?
        sum_w[15:0] : (sum_w[35] ? pss_pkg::OUT_MIN : pss_pkg::OUT_MAX);

    ////////////////////////////////////////////////////////////////////////
    // Update sequencer
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_q <= pss_pkg::PSS_IDLE;
        end else begin
            case (st_q)
                pss_pkg::PSS_IDLE: begin
                    if (tick_q) begin
                        st_q <= pss_pkg::PSS_SEL;
                    end
                end
                pss_pkg::PSS_SEL: st_q <= pss_pkg::PSS_INT;
                pss_pkg::PSS_INT: st_q <= pss_pkg::PSS_OUT;
                pss_pkg::PSS_OUT: st_q <= pss_pkg::PSS_IDLE;
                default: st_q <= pss_pkg::PSS_IDLE;
            endcase
        end
    end

    // Sample select code and setpoint once per update
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sel_code_q <= '0;
            setpoint_q <= '0;
            pid_active_q <= 1'b0;
            err_q <= '0;
        end else if (st_q == pss_pkg::PSS_SEL) begin
            sel_code_q <= code_w;
            setpoint_q <= sp_pick_w;
            pid_active_q <= pid_en_w;
            err_q <= err_w;
        end
    end

    // Integrator step
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            acc_q <= '0;
        end else if (st_q == pss_pkg::PSS_INT) begin
            if (!pid_active_q || ti_q == '0) begin
                acc_q <= '0;
            end else if (err_q != '0) begin
                acc_q <= acc_sat_w;
            end
        end
    end

    // Frequency command
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            freq_cmd_q <= '0;
        end else if (st_q == pss_pkg::PSS_OUT) begin
            freq_cmd_q <= pid_active_q ? out_w : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    chk_unused_term: assert property (
        (code_w != '0) |-> (|(di_s_q & nz_w)))
        else $error("select code set by an unassigned terminal");

    chk_bit1_lsb: assert property (
        (di_s_q[0] && fn_q[0] == pss_pkg::FN_BIT1) |-> code_w[0])
        else $error("terminal with code 1 not on select bit 1");

    chk_bit3_msb: assert property (
        (di_s_q[9] && fn_q[9] == pss_pkg::FN_BIT3) |-> code_w[2])
        else $error("terminal with code 3 not on select bit 3");

    chk_mode_off: assert property (
        (st_q == pss_pkg::PSS_SEL && mode_q == '0) |=>
        (setpoint_q == $past(dflt_sp_i) && !pid_active_q))
        else $error("stored setpoint used while PID is off");

    chk_default_src: assert property (
        (st_q == pss_pkg::PSS_SEL && code_w == '0) |=>
        (setpoint_q == $past(dflt_sp_i)))
        else $error("source setpoint not used with inputs off");

    chk_stored_pick: assert property (
        (st_q == pss_pkg::PSS_SEL && mode_q != '0 && code_w != '0) |=>
        (setpoint_q == $past(sp_q[idx_w]) && sel_code_q != '0))
        else $error("wrong stored setpoint for select code");

    chk_kp_range: assert property (kp_q <= pss_pkg::KP_MAX)
        else $error("gain above range");

    chk_ti_range: assert property (ti_q <= pss_pkg::TI_MAX)
        else $error("integral time above range");

    chk_int_off: assert property (
        (st_q == pss_pkg::PSS_INT && ti_q == '0) |=> (acc_q == '0))
        else $error("integrator active with zero time");

    chk_int_hold: assert property (
        (st_q == pss_pkg::PSS_INT && ti_q != '0 && err_q == '0 &&
         pid_active_q) |=> $stable(acc_q))
        else $error("integrator moved with zero error");

    chk_int_move: assert property (
        (st_q == pss_pkg::PSS_INT && ti_q != '0 && err_q != '0 &&
         pid_active_q && acc_q != pss_pkg::ACC_MAX &&
         acc_q != pss_pkg::ACC_MIN) |=> !$stable(acc_q))
        else $error("integrator stalled with nonzero error");

    chk_offset_add: assert property (
        (st_q == pss_pkg::PSS_OUT && pid_active_q && kp_q == '0 &&
         acc_q == '0) |=> (freq_cmd_q == $past(off_q)))
        else $error("offset not passed to command");

    chk_update_seq: assert property (
        (st_q == pss_pkg::PSS_IDLE && tick_q) |=>
        (st_q == pss_pkg::PSS_SEL) ##1 (st_q == pss_pkg::PSS_INT)
        ##1 (st_q == pss_pkg::PSS_OUT))
        else $error("update sequence broken");

endmodule // pss_core

`default_nettype wire

//--- bench/pss_contacts.sv
// Field contact model driving the digital input terminals
`timescale 1ns/1ps
`default_nettype none

module pss_contacts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Requested contact levels and stray-level terminals
    input wire logic [15:0] level_i,
    input wire logic [15:0] noise_en_i,
    // Terminal levels
    output logic [15:0] di_o
);
    logic [15:0] noise_q;

    // Stray levels that change every cycle on unused terminals
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            noise_q <= 16'hA5C3;
        end else begin
            noise_q <= noise_q + 16'h1357;
        end
    end

    // Mix real contacts with stray levels
    assign di_o = (level_i & ~noise_en_i) | (noise_q & noise_en_i);
endmodule // pss_contacts

`default_nettype wire

//--- bench/pid_setpoint_select_pi_terms_bench.sv
// Self-checking bench for setpoint selection and PI terms
`timescale 1ns/1ps
`default_nettype none

module pid_setpoint_select_pi_terms_bench;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    pss_pkg::pss_bus_t bus = '0;
    logic [15:0] rd_data_q;
    logic [15:0] level = 16'h0000;
    logic [15:0] noise_en = 16'h0000;
    logic [15:0] di;
    logic [15:0] pv = 16'h0000;
    logic [15:0] dflt = 16'h0000;
    logic signed [15:0] freq_cmd_q;
    logic [15:0] setpoint_q;
    logic [2:0] sel_code_q;
    logic pid_active_q;
    logic [15:0] rdata;
    logic [15:0] sp [7];
    logic [15:0] f0;
    int n_errors = 0;
    int tests_run = 0;
    int gain;
    int off;

    ////////////////////////////////////////////////////////////////////////
    // Clock, partner and design
    always #25 core_clk = ~core_clk;

    pss_contacts i_contacts (.core_clk(core_clk), .rstn(rstn),
        .level_i(level), .noise_en_i(noise_en), .di_o(di));

    pss_core #(.UPD_CYCLES(8)) i_dut (.core_clk(core_clk), .rstn(rstn),
        .bus_i(bus), .rd_data_q(rd_data_q), .di_i(di), .pv_i(pv),
        .dflt_sp_i(dflt), .freq_cmd_q(freq_cmd_q), .setpoint_q(setpoint_q),
        .sel_code_q(sel_code_q), .pid_active_q(pid_active_q));

    ////////////////////////////////////////////////////////////////////////
    // Bus tasks
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 rdata = rd_data_q;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Checking and verdict
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_change(input logic [15:0] a, input logic [15:0] b,
                              input logic moved);
        tests_run++;
        if (((a !== b) !== moved) || $isunknown(b)) begin
            n_errors++;
            $display("ERROR %0t output %h then %h", $time, a, b);
        end
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Proportional term plus offset, clipped to 16-bit signed
    function automatic logic [15:0] exp_p(int g, int err, int o);
        int v;
        v = g * err / 10 + o;
        if (v > 32767) v = 32767;
        if (v < -32768) v = -32768;
        return v[15:0];
    endfunction

    task automatic settle();
        repeat (24) @(posedge core_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(38));
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        // Defaults, clipping and an unmapped word
        rd(pss_pkg::A_KP);
        chk_word(rdata, pss_pkg::KP_RST);
        rd(pss_pkg::A_TI);
        chk_word(rdata, pss_pkg::TI_RST);
        rd(16'h0701);
        chk_word(rdata, 16'h0000);
        wr(pss_pkg::A_KP, 16'hFFFF);
        rd(pss_pkg::A_KP);
        chk_word(rdata, pss_pkg::KP_MAX);
        wr(pss_pkg::A_TI, 16'hFFFF);
        rd(pss_pkg::A_TI);
        chk_word(rdata, pss_pkg::TI_MAX);
        // Terminals 0, 5, 9 carry select bits; 14 gets an unknown code
        wr(pss_pkg::A_FN_BASE, 16'h0001);
        wr(pss_pkg::A_FN_BASE + 16'h0005, 16'h0002);
        wr(pss_pkg::A_FN_BASE + 16'h0009, 16'h0003);
        wr(pss_pkg::A_FN_BASE + 16'h000E, 16'h0004);
        noise_en <= 16'hFDDE;
        for (int i = 0; i < 7; i++) begin
            sp[i] = 16'($urandom_range(1, 10000));
            wr(pss_pkg::A_SP_BASE + 16'(i), sp[i]);
        end
        dflt <= 16'($urandom_range(0, 10000));
        // Mode zero: no stored setpoint, no output
        level <= 16'h0221;
        settle();
        chk_word(setpoint_q, dflt);
        chk_word({15'h0000, pid_active_q}, 16'h0000);
        chk_word(freq_cmd_q, 16'h0000);
        wr(pss_pkg::A_MODE, 16'($urandom_range(1, 6)));
        // Every select code, with stray levels elsewhere
        for (int c = 0; c < 8; c++) begin
            level <= {6'h00, c[2], 3'h0, c[1], 4'h0, c[0]};
            settle();
            chk_word({13'h0000, sel_code_q}, 16'(c));
            chk_word(setpoint_q, c == 0 ? dflt : sp[c - 1]);
            chk_word({15'h0000, pid_active_q}, 16'h0001);
        end
        // Status, stored setpoint and function code read back
        rd(pss_pkg::A_STATUS);
        chk_word(rdata, 16'h0007 | (16'h0001 << pss_pkg::STAT_ACT_BIT));
        rd(pss_pkg::A_SP_BASE + 16'h0006);
        chk_word(rdata, sp[6]);
        rd(pss_pkg::A_FN_BASE + 16'h0009);
        chk_word(rdata, 16'h0003);
        // Proportional only, with offset
        wr(pss_pkg::A_TI, 16'h0000);
        level <= 16'h0000;
        for (int k = 0; k < 6; k++) begin
            gain = (k == 0) ? 1000 : int'($urandom_range(0, 1000));
            off = int'($urandom_range(0, 400)) - 200;
            wr(pss_pkg::A_KP, 16'(gain));
            wr(pss_pkg::A_OFFSET, 16'(off));
            dflt <= 16'($urandom_range(0, 2000));
            pv <= (k == 0) ? 16'h0000 : 16'($urandom_range(0, 2000));
            settle();
            chk_word(freq_cmd_q,
                exp_p(gain, int'(dflt) - int'(pv), off));
            rd(pss_pkg::A_FREQ);
            chk_word(rdata, exp_p(gain, int'(dflt) - int'(pv), off));
        end
        // Integral action grows while the error stands
        wr(pss_pkg::A_KP, 16'h0000);
        wr(pss_pkg::A_OFFSET, 16'h0000);
        wr(pss_pkg::A_TI, 16'h0001);
        dflt <= 16'h0200;
        pv <= 16'h019C;
        settle();
        f0 = freq_cmd_q;
        repeat (16) @(posedge core_clk);
        #1 chk_change(f0, freq_cmd_q, 1'b1);
        // Zero error holds the integral
        pv <= 16'h0200;
        settle();
        f0 = freq_cmd_q;
        repeat (16) @(posedge core_clk);
        #1 chk_change(f0, freq_cmd_q, 1'b0);
        // Zero integral time removes the term
        wr(pss_pkg::A_TI, 16'h0000);
        settle();
        chk_word(freq_cmd_q, 16'h0000);
        print_verdict();
    end
endmodule // pid_setpoint_select_pi_terms_bench

`default_nettype wire
